// file: design/cipher_engine.sv
// Iterative AES-128 engine, one round per clock, behind the byte window 0x82-0x94.
// Assumes the host keeps to its side of the link and strobes never overlap.
`timescale 1ns/100ps
`default_nettype none
module cipher_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Transceiver power state
  input wire logic sleep_state,
  input wire logic deepest_power_down_state,
  // Access from the host
  cipher_link_if.dev link,
  // Engine state
  output logic run_busy,
  output logic run_done
);
  import cipher_pkg::*;

  typedef struct packed {
    logic [2:0] mode;
    logic dir;
    cipher_pkg::block_t key_init;
    cipher_pkg::block_t round_key;
    cipher_pkg::block_t data;
    cipher_pkg::block_t chain;
    logic busy;
    logic dec;
    logic [3:0] round;
    logic done;
    logic fault;
    logic pending;
    logic [15:0] seen;
    logic [7:0] rdata;
  } engine_s;

  engine_s q, d;

  function automatic logic [7:0] xtime(input logic [7:0] b);
    xtime = {b[6:0], 1'b0} ^ (b[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xtime(x);
    end
    gmul = p;
  endfunction

  // Inverse as a^254; zero maps to zero as the cipher wants
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] sq;
    r = 8'h01;
    sq = a;
    for (int i = 1; i < 8; i++) begin
      sq = gmul(sq, sq);
      r = gmul(r, sq);
    end
    ginv = r;
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] b, input int n);
    rotl = 8'((b << n) | (b >> (8 - n)));
  endfunction

  // Computed rather than tabled: smaller source, deeper logic
  function automatic logic [7:0] sbox(input logic [7:0] b);
    logic [7:0] v;
    v = ginv(b);
    sbox = v ^ rotl(v, 1) ^ rotl(v, 2) ^ rotl(v, 3) ^ rotl(v, 4) ^ 8'h63;
  endfunction

  function automatic logic [7:0] inv_sbox(input logic [7:0] b);
    inv_sbox = ginv(rotl(b, 1) ^ rotl(b, 3) ^ rotl(b, 6) ^ 8'h05);
  endfunction

  function automatic logic [7:0] rcon(input logic [3:0] r);
    logic [7:0] x;
    x = 8'h01;
    for (int i = 1; i < 10; i++) begin
      if (4'(i) < r) x = xtime(x);
    end
    rcon = x;
  endfunction

  function automatic block_t mix(input block_t s, input logic [3:0][7:0] c);
    block_t u;
    for (int col = 0; col < 4; col++) begin
      for (int j = 0; j < 4; j++) begin
        u[4 * col + j] = 8'h00;
        for (int k = 0; k < 4; k++) begin
          u[4 * col + j] = u[4 * col + j] ^ gmul(s[4 * col + (j + k) % 4], c[k]);
        end
      end
    end
    mix = u;
  endfunction

  function automatic block_t enc_round(input block_t s, input block_t k, input logic last);
    block_t t;
    for (int i = 0; i < 16; i++) begin
      t[i] = sbox(s[(i + 4 * (i % 4)) % 16]);
    end
    enc_round = (last ? t : mix(t, {8'h01, 8'h01, 8'h03, 8'h02})) ^ k;
  endfunction

  function automatic block_t dec_round(input block_t s, input block_t k, input logic last);
    block_t t;
    for (int i = 0; i < 16; i++) begin
      t[i] = inv_sbox(s[(i + 12 * (i % 4)) % 16]) ^ k[i];
    end
    dec_round = last ? t : mix(t, {8'h09, 8'h0D, 8'h0B, 8'h0E});
  endfunction

  // Next round key forward, or previous one backward for decryption
  function automatic block_t key_step(input block_t k, input logic [3:0] r, input logic fwd);
    block_t n;
    logic [3:0][7:0] w3;
    logic [3:0][7:0] t;
    for (int j = 0; j < 4; j++) begin
      w3[j] = fwd ? k[12 + j] : k[12 + j] ^ k[8 + j];
    end
    for (int j = 0; j < 4; j++) begin
      t[j] = sbox(w3[(j + 1) % 4]) ^ (j == 0 ? rcon(r) : 8'h00);
    end
    for (int j = 0; j < 4; j++) begin
      if (fwd) begin
        n[j] = k[j] ^ t[j];
        n[4 + j] = k[4 + j] ^ n[j];
        n[8 + j] = k[8 + j] ^ n[4 + j];
        n[12 + j] = k[12 + j] ^ n[8 + j];
      end else begin
        n[12 + j] = w3[j];
        n[8 + j] = k[8 + j] ^ k[4 + j];
        n[4 + j] = k[4 + j] ^ k[j];
        n[j] = k[j] ^ t[j];
      end
    end
    key_step = n;
  endfunction

  logic access;
  logic in_block;
  logic ctrl_hit;
  logic [3:0] idx;
  logic [2:0] wmode;
  logic wdir;
  block_t step_key;
  logic last_round;

  assign access = ~sleep_state & ~deepest_power_down_state & (link.we | link.re);
  assign in_block = link.addr >= ADDR_BLOCK_FIRST && link.addr <= ADDR_BLOCK_LAST;
  assign ctrl_hit = link.addr == ADDR_CTRL || link.addr == ADDR_CTRL_ALIAS;
  assign idx = 4'(link.addr - ADDR_BLOCK_FIRST);
  assign wmode = link.wdata[CTRL_MODE_LSB +: 3];
  assign wdir = link.wdata[CTRL_DIR_BIT];
  assign step_key = key_step(q.round_key, q.round, ~q.dec);
  assign last_round = q.dec ? (q.round == 4'h1) : (q.round == ROUNDS);

  always_comb begin
    d = q;
    d.rdata = 8'h00;
    // Rounds advance on their own through sleep; only deepest power down stops them
    if (q.busy) begin
      d.round_key = step_key;
      d.data = q.dec ? dec_round(q.data, step_key, last_round) : enc_round(q.data, step_key, last_round);
      if (last_round) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.pending = 1'b1;
        d.seen = 16'h0000;
        if (!q.dec) d.chain = d.data;
      end else begin
        d.round = q.dec ? q.round - 4'h1 : q.round + 4'h1;
      end
    end
    if (access) begin
      if (link.re) begin
        if (link.addr == ADDR_STATUS) begin
          d.rdata[STATUS_FAULT_BIT] = q.fault;
          d.rdata[STATUS_DONE_BIT] = q.done;
        end else if (ctrl_hit) begin
          d.rdata[CTRL_MODE_LSB +: 3] = q.mode;
          d.rdata[CTRL_DIR_BIT] = q.dir;
        end else if (in_block) begin
          d.rdata = (q.mode == MODE_KEY) ? q.round_key[idx] : q.data[idx];
          if (q.mode != MODE_KEY) d.seen[idx] = 1'b1;
        end
      end
      if (link.we && in_block) begin
        if (q.mode == MODE_KEY) begin
          d.key_init[idx] = link.wdata;
          d.round_key[idx] = link.wdata;
        end else begin
          // Old result shifts out as new data shifts in
          d.rdata = q.data[idx];
          d.seen[idx] = 1'b1;
          d.data[idx] = link.wdata;
        end
      end
      // A run finishing in this very cycle wins over the abort
      if (ctrl_hit && q.busy && !last_round) begin
        d.busy = 1'b0;
        d.done = 1'b0;
        d.fault = 1'b1;
      end
      if (ctrl_hit && link.we) begin
        d.mode = wmode;
        d.dir = wdir;
        // Reserved modes and key mode never start a run
        if (link.wdata[CTRL_REQ_BIT] && !q.busy && (wmode == MODE_ECB || wmode == MODE_CBC)) begin
          d.fault = q.pending && q.seen != ALL_BYTES;
          d.busy = 1'b1;
          d.done = 1'b0;
          d.pending = 1'b0;
          d.dec = wdir && wmode == MODE_ECB;
          d.data = q.data ^ q.key_init ^ (wmode == MODE_CBC ? q.chain : '0);
          d.round_key = q.key_init;
          d.round = wdir && wmode == MODE_ECB ? ROUNDS : 4'h1;
        end
      end
    end
    if (deepest_power_down_state) d = '0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.rdata = q.rdata;
  assign run_busy = q.busy;
  assign run_done = q.done;
endmodule
`default_nettype wire

// file: design/cipher_host.sv
// Host-side sequencer that drives the cipher engine over the byte link.
// Assumes software talks through a plain strobe port; read data one cycle later.
`timescale 1ns/100ps
`default_nettype none
module cipher_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Software port
  input wire logic [5:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_we,
  input wire logic sw_re,
  output logic [7:0] sw_rdata,
  // Link to the engine
  cipher_link_if.host link
);
  import cipher_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_CTRL, H_FILL, H_START, H_POLL, H_POLL_CHK, H_READ, H_READ_CAP} host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [2:0] op;
    logic dir;
    logic [1:0] stage;
    logic [3:0] idx;
    cipher_pkg::block_t block;
    cipher_pkg::block_t iv;
    logic fault;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic hold;
    logic [7:0] sw_rdata;
  } host_s;

  host_s q, d;
  logic [2:0] mode;
  logic [7:0] ctrl_byte;

  always_comb begin
    if (q.op == OP_LOAD_KEY || q.stage != 2'h0) begin
      mode = MODE_KEY;
    end else if (q.op == OP_CHAIN_NEXT) begin
      mode = MODE_CBC;
    end else begin
      mode = MODE_ECB;
    end
    ctrl_byte = 8'h00;
    ctrl_byte[CTRL_MODE_LSB +: 3] = mode;
    ctrl_byte[CTRL_DIR_BIT] = q.dir;
  end

  always_comb begin
    d = q;
    d.we = 1'b0;
    d.re = 1'b0;
    d.sw_rdata = 8'h00;
    if (sw_re) begin
      if (sw_addr < HOST_ADDR_IV) begin
        d.sw_rdata = q.block[sw_addr[3:0]];
      end else if (sw_addr < HOST_ADDR_CMD) begin
        d.sw_rdata = q.iv[sw_addr[3:0]];
      end else if (sw_addr == HOST_ADDR_STATUS) begin
        d.sw_rdata = {6'h00, q.fault, q.state != H_IDLE};
      end
    end
    // Buffers are frozen against software writes while a sequence runs
    if (sw_we && q.state == H_IDLE) begin
      if (sw_addr < HOST_ADDR_IV) begin
        d.block[sw_addr[3:0]] = sw_wdata;
      end else if (sw_addr < HOST_ADDR_CMD) begin
        d.iv[sw_addr[3:0]] = sw_wdata;
      end else if (sw_addr == HOST_ADDR_CMD) begin
        d.op = sw_wdata[2:0];
        // Chaining and key derivation only ever encrypt
        d.dir = sw_wdata[CMD_DIR_BIT] && sw_wdata[2:0] == OP_ECB;
        d.stage = 2'h0;
        d.state = H_CTRL;
      end
    end
    case (q.state)
      H_IDLE: begin
      end
      H_CTRL: begin
        d.we = 1'b1;
        d.addr = ADDR_CTRL;
        d.wdata = ctrl_byte;
        d.idx = 4'h0;
        d.state = q.stage == 2'h1 ? H_READ : H_FILL;
      end
      H_FILL: begin
        d.we = 1'b1;
        d.addr = ADDR_BLOCK_FIRST + 8'(q.idx);
        d.wdata = q.op == OP_CHAIN_FIRST ? q.block[q.idx] ^ q.iv[q.idx] : q.block[q.idx];
        d.idx = q.idx + 4'h1;
        if (q.idx == 4'hF) begin
          d.state = (q.op == OP_LOAD_KEY || q.stage == 2'h2) ? H_IDLE : H_START;
        end
      end
      H_START: begin
        d.we = 1'b1;
        d.addr = ADDR_CTRL_ALIAS;
        d.wdata = ctrl_byte | 8'h80;
        d.state = H_POLL;
      end
      H_POLL: begin
        d.re = 1'b1;
        d.addr = ADDR_STATUS;
        d.state = H_POLL_CHK;
      end
      H_POLL_CHK: begin
        // Answer stands only in the cycle after the strobe; first cycle waits
        d.hold = ~q.hold;
        if (q.hold) begin
          d.idx = 4'h0;
          d.fault = link.rdata[STATUS_FAULT_BIT];
          d.state = link.rdata[STATUS_DONE_BIT] ? H_READ : H_POLL;
        end
      end
      H_READ: begin
        d.re = 1'b1;
        d.addr = ADDR_BLOCK_FIRST + 8'(q.idx);
        d.state = H_READ_CAP;
      end
      H_READ_CAP: begin
        d.hold = ~q.hold;
        if (q.hold) begin
          d.block[q.idx] = link.rdata;
          d.idx = q.idx + 4'h1;
          d.state = H_READ;
          if (q.idx == 4'hF) begin
            d.state = H_IDLE;
            // Dummy run done: fetch the last round key, then load it back
            if (q.op == OP_DERIVE_KEY && q.stage != 2'h2) begin
              d.stage = q.stage + 2'h1;
              d.state = H_CTRL;
            end
          end
        end
      end
      default: begin
        d.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.addr = q.addr;
  assign link.wdata = q.wdata;
  assign link.we = q.we;
  assign link.re = q.re;
  assign sw_rdata = q.sw_rdata;
endmodule
`default_nettype wire

// file: design/cipher_link_if.sv
// Byte-wide memory-style link between host controller and cipher engine.
// Assumes both ends share clk; read data stand one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
interface cipher_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic we;
  logic re;
  logic [7:0] rdata;
  modport host (output addr, output wdata, output we, output re, input rdata);
  modport dev (input addr, input wdata, input we, input re, output rdata);
endinterface
`default_nettype wire

// file: design/cipher_pkg.sv
// Constants shared by the cipher engine, its host controller and the link.
// Assumes one 200 MHz clock and a memory-style byte link between the two ends.
package cipher_pkg;
  // Device address map
  localparam logic [7:0] ADDR_STATUS = 8'h82;
  localparam logic [7:0] ADDR_CTRL = 8'h83;
  localparam logic [7:0] ADDR_BLOCK_FIRST = 8'h84;
  localparam logic [7:0] ADDR_BLOCK_LAST = 8'h93;
  localparam logic [7:0] ADDR_CTRL_ALIAS = 8'h94;
  // Field positions
  localparam int CTRL_REQ_BIT = 7;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_DIR_BIT = 3;
  localparam int STATUS_FAULT_BIT = 7;
  localparam int STATUS_DONE_BIT = 0;
  // Mode field values
  localparam logic [2:0] MODE_ECB = 3'h0;
  localparam logic [2:0] MODE_KEY = 3'h1;
  localparam logic [2:0] MODE_CBC = 3'h2;
  // Engine timing and byte-seen mask
  localparam logic [3:0] ROUNDS = 4'hA;
  localparam logic [15:0] ALL_BYTES = 16'hFFFF;
  localparam int RUN_TIME_NS = 24000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RUN_LIMIT_CYCLES = RUN_TIME_NS / CLK_PERIOD_NS;
  // Host controller software map
  localparam logic [5:0] HOST_ADDR_BLOCK = 6'h00;
  localparam logic [5:0] HOST_ADDR_IV = 6'h10;
  localparam logic [5:0] HOST_ADDR_CMD = 6'h20;
  localparam logic [5:0] HOST_ADDR_STATUS = 6'h21;
  localparam int CMD_DIR_BIT = 3;
  // Host operations
  localparam logic [2:0] OP_LOAD_KEY = 3'h0;
  localparam logic [2:0] OP_ECB = 3'h1;
  localparam logic [2:0] OP_CHAIN_FIRST = 3'h2;
  localparam logic [2:0] OP_CHAIN_NEXT = 3'h3;
  localparam logic [2:0] OP_DERIVE_KEY = 3'h4;
  typedef logic [15:0][7:0] block_t;
endpackage

// file: testbench/cipher_link_checker.sv
// Checker on the link between host sequencer and cipher engine.
// Assumes one clock, sync active-high reset, engine power inputs tied off.
`timescale 1ns/100ps
`default_nettype none
module cipher_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link and engine state
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic we,
  input wire logic re,
  input wire logic [7:0] rdata,
  input wire logic run_busy,
  input wire logic run_done
);
  import cipher_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic ctl_any;
  logic ctl_wr;
  logic [2:0] mode_w;
  assign ctl_any = (we || re) && (addr == ADDR_CTRL || addr == ADDR_CTRL_ALIAS);
  assign ctl_wr = ctl_any && we;
  assign mode_w = wdata[CTRL_MODE_LSB +: 3];
  // Counts back-to-back busy cycles, so a long run needs no unrolled repetition
  logic [3:0] busy_len_q;
  always_ff @(posedge clk) begin
    if (reset || !run_busy) begin
      busy_len_q <= 4'h0;
    end else begin
      busy_len_q <= busy_len_q + 4'h1;
    end
  end
  sequence s_rounds;
    ##9 (run_busy && busy_len_q == ROUNDS - 4'h1);
  endsequence
  sequence s_finish;
    !run_busy && run_done;
  endsequence
  AST_START_BUSY:
    assert property (ctl_wr && wdata[CTRL_REQ_BIT] && !run_busy && (mode_w == MODE_ECB || mode_w == MODE_CBC)
      |=> run_busy) else $error("start write did not start a run");
  AST_RUN_LEN:
    assert property ($rose(run_busy) |-> s_rounds ##1 s_finish) else $error("run length or done wrong");
  AST_BUSY_NO_DONE:
    assert property (run_busy |-> !run_done) else $error("done high during run");
  AST_DONE_HOLD:
    assert property (run_done && !ctl_any |=> run_done) else $error("done dropped by itself");
  AST_RDATA_IDLE:
    assert property (!$past(we) && !$past(re) |-> rdata == 8'h00) else $error("read data without access");
  AST_STATUS_READ:
    assert property (re && addr == ADDR_STATUS |=> rdata[STATUS_DONE_BIT] == $past(run_done))
      else $error("status done bit wrong");
  AST_ONE_STROBE:
    assert property (!(we && re)) else $error("both strobes high");
  AST_QUIET_RUN:
    assert property (run_busy |-> !ctl_any) else $error("control touched during run");
  AST_CBC_ENC:
    assert property (ctl_wr && mode_w == MODE_CBC |-> !wdata[CTRL_DIR_BIT]) else $error("chaining with decrypt");
  AST_BURST_ORDER:
    assert property (we && addr == ADDR_CTRL_ALIAS |-> $past(we) && $past(addr) == ADDR_BLOCK_LAST)
      else $error("start not at end of burst");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Host sequencer and engine joined by the link, plus a second engine driven here.
// Assumes 200 MHz clock; the second engine takes rule-breaking host traffic.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cipher_pkg::*;
  localparam block_t KEY = 128'h0F0E0D0C0B0A09080706050403020100;
  localparam block_t PT = 128'hFFEEDDCCBBAA99887766554433221100;
  localparam block_t CT = 128'h5AC5B47080B7CDD830047B6AD8E0C469;
  localparam block_t RK = 128'hC5302B4D8BA707F3174A94E37F1D1113;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] sw_addr = 6'h00;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_we = 1'b0;
  logic sw_re = 1'b0;
  logic sleep2 = 1'b0;
  logic deep2 = 1'b0;
  logic [7:0] sw_rdata;
  logic busy, done, busy2, done2;
  logic [7:0] q;
  int failures = 0;
  int num_checks = 0;
  cipher_link_if link ();
  cipher_link_if link2 ();
  cipher_host u_cipher_host (.clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .link(link));
  cipher_engine u_cipher_engine (.clk(clk), .reset(reset), .sleep_state(1'b0),
    .deepest_power_down_state(1'b0), .link(link), .run_busy(busy), .run_done(done));
  // Second engine so that host faults can be injected
  cipher_engine u_cipher_engine_2 (.clk(clk), .reset(reset), .sleep_state(sleep2),
    .deepest_power_down_state(deep2), .link(link2), .run_busy(busy2), .run_done(done2));
  cipher_link_checker u_cipher_link_checker (.clk(clk), .reset(reset), .addr(link.addr), .wdata(link.wdata),
    .we(link.we), .re(link.re), .rdata(link.rdata), .run_busy(busy), .run_done(done));
  always #2.5 clk = ~clk;
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One strobe, one idle cycle after it; q holds read data
  task automatic sw(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_we <= w;
    sw_re <= !w;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_we <= 1'b0;
    sw_re <= 1'b0;
    #1 q = sw_rdata;
  endtask
  // Released lines show the inverse so stale values never pass
  task automatic lk(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    link2.we <= w;
    link2.re <= !w;
    link2.addr <= a;
    link2.wdata <= d;
    @(posedge clk);
    link2.we <= 1'b0;
    link2.re <= 1'b0;
    link2.addr <= ~a;
    link2.wdata <= ~d;
    #1 q = link2.rdata;
  endtask
  task automatic blk_set(input block_t b);
    for (int i = 0; i < 16; i++) sw(1'b1, HOST_ADDR_BLOCK + 6'(i), b[i]);
  endtask
  task automatic blk_chk(input block_t b);
    for (int i = 0; i < 16; i++) begin
      sw(1'b0, HOST_ADDR_BLOCK + 6'(i), 8'h00);
      cmp8(q, b[i]);
    end
  endtask
  // Polling is bounded; a stuck sequence leaves busy set and fails
  task automatic run_op(input logic [7:0] cmd);
    sw(1'b1, HOST_ADDR_CMD, cmd);
    for (int n = 0; n < 400; n++) begin
      sw(1'b0, HOST_ADDR_STATUS, 8'h00);
      if (q[0] === 1'b0) break;
    end
    cmp8(q, 8'h00);
  endtask
  task automatic t_reset();
    sw(1'b0, HOST_ADDR_STATUS, 8'h00);
    cmp8(q, 8'h00);
    sw(1'b0, HOST_ADDR_IV, 8'h00);
    cmp8(q, 8'h00);
    cmp1(busy, 1'b0);
    cmp1(done, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_ecb();
    blk_set(KEY);
    run_op(8'h00);
    blk_set(PT);
    run_op(8'h01);
    blk_chk(CT);
    cmp1(done, 1'b1);
    blk_set(PT);
    run_op(8'h01);
    blk_chk(CT);
    $display("test ecb done");
  endtask
  task automatic t_cbc();
    for (int i = 0; i < 16; i++) sw(1'b1, HOST_ADDR_IV + 6'(i), PT[i]);
    blk_set(128'h0);
    run_op(8'h02);
    blk_chk(CT);
    blk_set(CT ^ PT);
    run_op(8'h03);
    blk_chk(CT);
    $display("test chain done");
  endtask
  task automatic t_dec();
    blk_set(PT);
    run_op(8'h04);
    blk_chk(RK);
    run_op(8'h00);
    blk_set(CT);
    run_op(8'h09);
    blk_chk(PT);
    $display("test decrypt done");
  endtask
  task automatic t_direct();
    lk(1'b1, ADDR_CTRL, 8'h10);
    for (int i = 0; i < 16; i++) lk(1'b1, ADDR_BLOCK_FIRST + 8'(i), KEY[i]);
    lk(1'b1, ADDR_CTRL, 8'h00);
    for (int i = 0; i < 16; i++) lk(1'b1, ADDR_BLOCK_FIRST + 8'(i), PT[i]);
    lk(1'b1, ADDR_CTRL_ALIAS, 8'h80);
    repeat (12) @(posedge clk);
    lk(1'b0, ADDR_STATUS, 8'h00);
    cmp8(q, 8'h01);
    cmp1(done2, 1'b1);
    for (int i = 0; i < 16; i++) begin
      lk(1'b1, ADDR_BLOCK_FIRST + 8'(i), PT[i]);
      cmp8(q, CT[i]);
    end
    lk(1'b1, ADDR_CTRL_ALIAS, 8'h80);
    repeat (12) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      lk(1'b0, ADDR_BLOCK_FIRST + 8'(i), 8'h00);
      cmp8(q, CT[i]);
    end
    lk(1'b1, ADDR_CTRL, 8'h10);
    for (int i = 0; i < 16; i++) begin
      lk(1'b0, ADDR_BLOCK_FIRST + 8'(i), 8'h00);
      cmp8(q, RK[i]);
    end
    lk(1'b0, ADDR_CTRL_ALIAS, 8'h00);
    cmp8(q, 8'h10);
    lk(1'b0, 8'h95, 8'h00);
    cmp8(q, 8'h00);
    $display("test direct done");
  endtask
  task automatic t_abort();
    lk(1'b1, ADDR_CTRL, 8'h00);
    lk(1'b1, ADDR_CTRL_ALIAS, 8'h80);
    cmp1(busy2, 1'b1);
    lk(1'b0, ADDR_CTRL, 8'h00);
    cmp1(busy2, 1'b0);
    cmp1(done2, 1'b0);
    lk(1'b0, ADDR_STATUS, 8'h00);
    cmp8(q, 8'h80);
    $display("test abort done");
  endtask
  task automatic t_power();
    @(posedge clk);
    sleep2 <= 1'b1;
    lk(1'b0, ADDR_STATUS, 8'h00);
    cmp8(q, 8'h00);
    lk(1'b1, ADDR_CTRL, 8'h10);
    @(posedge clk);
    sleep2 <= 1'b0;
    lk(1'b0, ADDR_CTRL, 8'h00);
    cmp8(q, 8'h00);
    lk(1'b0, ADDR_STATUS, 8'h00);
    cmp8(q, 8'h80);
    @(posedge clk);
    deep2 <= 1'b1;
    @(posedge clk);
    deep2 <= 1'b0;
    lk(1'b0, ADDR_STATUS, 8'h00);
    cmp8(q, 8'h00);
    lk(1'b0, ADDR_BLOCK_FIRST, 8'h00);
    cmp8(q, 8'h00);
    $display("test power done");
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs well under two thousand cycles; this leaves ample margin
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    link2.addr = 8'h00;
    link2.wdata = 8'h00;
    link2.we = 1'b0;
    link2.re = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_ecb();
    t_cbc();
    t_dec();
    t_direct();
    t_abort();
    t_power();
    wrap_up();
  end
endmodule
`default_nettype wire
